// File: pkg/adc_list_ctrl_defs.svh
`ifndef ADC_LIST_CTRL_DEFS_SVH
`define ADC_LIST_CTRL_DEFS_SVH
`define ADDR_CONTROL_ONE 3'h1
`define ADDR_STATUS     3'h2
`define ADDR_COMMAND    3'h6
`define BIT_CMD_BMOD    7
`define BIT_RES_BMOD    6
`define BIT_SPECIAL     5
`define BIT_AUTO_RESTART_REQUEST   4
`define BIT_CMD_SEL     7
`define BIT_RES_SEL     6
`define BIT_ECC_FAULT   5
`define BIT_READY       3
`define BYTE_ZERO       8'h00
`endif

// File: pkg/adc_list_ctrl_pkg.sv
package adc_list_ctrl_pkg;
	typedef enum logic [1:0] {st_idle, st_load, st_convert, st_halted}
		conv_state_type;

	typedef struct packed {
		logic           cmd_bmod_q;
		logic           res_bmod_q;
		logic           special_q;
		logic           auto_restart_request_q;
		logic           cmd_sel_q;
		logic           res_sel_q;
		logic           first_stored_q;
		logic           ecc_fault_q;
		logic           load_ok_q;
		logic           restart_q;
		logic           wake_restart_q;
		logic           ready_q;
		logic           cmd_write_q;
		logic [7:0]     cmd_data_q;
		logic [7:0]     rdata_q;
		conv_state_type state_q;
	} regs_type;
endpackage : adc_list_ctrl_pkg

// File: rtl/adc_list_ctrl.sv
`timescale 1ns/1ps
`include "adc_list_ctrl_defs.svh"

module adc_list_ctrl
	import adc_list_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       clock_enable,
	// Register port
	input  wire logic [2:0] addr,
	input  wire logic       write_strobe,
	input  wire logic       read_strobe,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata,
	// Chip mode and converter context
	input  wire logic       converter_enable,
	input  wire logic       special_mode,
	input  wire logic       soft_reset,
	input  wire logic       stop_in_wait,
	input  wire logic       stop_exit,
	input  wire logic       wait_exit,
	// Flow control handshake
	input  wire logic       list_load_ok,
	input  wire logic       restart_request,
	input  wire logic       sequence_abort_request,
	// Datapath events
	input  wire logic       conversion_start,
	input  wire logic       list_end,
	input  wire logic       result_stored,
	input  wire logic       ecc_double_error,
	// Outputs
	output logic            cmd_list_buffer_mode,
	output logic            result_list_buffer_mode,
	output logic            cmd_list_select,
	output logic            result_list_select,
	output logic            double_bit_ecc_fault,
	output logic            ready,
	output logic            auto_restart_event,
	output logic            current_command_write,
	output logic [7:0]      current_command_data
);

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic guarded_ok(input logic en, input logic spec);
		guarded_ok = !en || spec;
	endfunction : guarded_ok

	regs_type r_q;
	regs_type r_d;
	logic     unlocked;
	logic     wr_ctl;
	logic     wr_sts;
	logic     flow_active;
	logic     restart_evt;

	assign unlocked    = guarded_ok(converter_enable, r_q.special_q);
	assign wr_ctl      = write_strobe && (addr == `ADDR_CONTROL_ONE);
	assign wr_sts      = write_strobe && (addr == `ADDR_STATUS);
	assign flow_active = converter_enable && !soft_reset;
	assign restart_evt = r_q.restart_q || r_q.wake_restart_q;

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb
	begin
		r_d = r_q;
		r_d.cmd_write_q    = 1'b0;
		r_d.wake_restart_q = 1'b0;

		// Control register writes
		if (wr_ctl && unlocked)
		begin
			r_d.cmd_bmod_q = wdata[`BIT_CMD_BMOD];
			r_d.res_bmod_q = wdata[`BIT_RES_BMOD];
		end
		if (wr_ctl && special_mode)
			r_d.special_q = wdata[`BIT_SPECIAL];
		if (!special_mode)
			r_d.special_q = 1'b0;
		if (wr_ctl)
			r_d.auto_restart_request_q = wdata[`BIT_AUTO_RESTART_REQUEST];

		// Wake restart: stop exit, or wait exit with stop-in-wait
		if (r_q.auto_restart_request_q && flow_active
			&& (stop_exit || (wait_exit && stop_in_wait)))
			r_d.wake_restart_q = 1'b1;

		// Flow control handshake copies; held clear when off
		if (!flow_active)
		begin
			r_d.load_ok_q = 1'b0;
			r_d.restart_q = 1'b0;
		end
		else
		begin
			r_d.load_ok_q = list_load_ok;
			r_d.restart_q = restart_request;
		end

		// Current command write under special access, before start
		if (write_strobe && addr == `ADDR_COMMAND && r_q.special_q
			&& r_q.state_q != st_convert && !conversion_start)
		begin
			r_d.cmd_write_q = 1'b1;
			r_d.cmd_data_q  = wdata;
		end

		// Sequencer state
		case (r_q.state_q)
			st_idle:
				if (restart_evt && flow_active)
				begin
					r_d.state_q = st_load;
					if (r_q.cmd_bmod_q && r_q.load_ok_q)
						r_d.cmd_sel_q = !r_q.cmd_sel_q;
				end
			st_load:
				if (conversion_start)
					r_d.state_q = st_convert;
			st_convert:
				if (list_end || sequence_abort_request)
					r_d.state_q = st_idle;
			st_halted:
				r_d.state_q = st_halted;
			default:
				r_d.state_q = st_idle;
		endcase

		// Result list toggle; first list stored does not toggle
		if (sequence_abort_request && r_q.state_q != st_idle)
		begin
			if (r_q.res_bmod_q && r_q.first_stored_q)
				r_d.res_sel_q = !r_q.res_sel_q;
		end
		else if (result_stored && r_q.state_q == st_convert)
		begin
			if (r_q.res_bmod_q && r_q.first_stored_q)
				r_d.res_sel_q = !r_q.res_sel_q;
			r_d.first_stored_q = 1'b1;
		end

		// Status select writes
		if (wr_sts && unlocked)
		begin
			r_d.cmd_sel_q = wdata[`BIT_CMD_SEL];
			r_d.res_sel_q = wdata[`BIT_RES_SEL];
		end

		// ECC fault: set wins over everything but disable and soft reset
		if (ecc_double_error && flow_active
			&& r_q.state_q != st_idle)
		begin
			r_d.ecc_fault_q = 1'b1;
			r_d.state_q     = st_halted;
		end
		if (!converter_enable)
			r_d.ecc_fault_q = 1'b0;

		if (soft_reset || !converter_enable)
		begin
			r_d.state_q        = st_idle;
			r_d.first_stored_q = 1'b0;
		end
		if (soft_reset)
		begin
			r_d.cmd_sel_q   = 1'b0;
			r_d.res_sel_q   = 1'b0;
			r_d.ecc_fault_q = 1'b0;
		end

		// Single buffer modes pin selects low
		if (!r_d.cmd_bmod_q)
			r_d.cmd_sel_q = 1'b0;
		if (!r_d.res_bmod_q)
			r_d.res_sel_q = 1'b0;

		// Ready reflects next state idle with no abort pending and the flow active
		r_d.ready_q = (r_d.state_q == st_idle)
			&& !sequence_abort_request && flow_active;

		// Read data; writes never touch ready or fault
		r_d.rdata_q = `BYTE_ZERO;
		if (read_strobe)
		begin
			case (addr)
				`ADDR_CONTROL_ONE:
				begin
					r_d.rdata_q[`BIT_CMD_BMOD]  = r_q.cmd_bmod_q;
					r_d.rdata_q[`BIT_RES_BMOD]  = r_q.res_bmod_q;
					r_d.rdata_q[`BIT_SPECIAL]   = r_q.special_q;
					r_d.rdata_q[`BIT_AUTO_RESTART_REQUEST] = r_q.auto_restart_request_q;
				end
				`ADDR_STATUS:
				begin
					r_d.rdata_q[`BIT_CMD_SEL]   = r_q.cmd_sel_q;
					r_d.rdata_q[`BIT_RES_SEL]   = r_q.res_sel_q;
					r_d.rdata_q[`BIT_ECC_FAULT] = r_q.ecc_fault_q;
					r_d.rdata_q[`BIT_READY]     = r_q.ready_q;
				end
				default:
					r_d.rdata_q = `BYTE_ZERO;
			endcase
		end
	end

	// ********************************************************
	// State register
	// ********************************************************
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			r_q         <= '0;
			r_q.state_q <= st_idle;
		end
		else if (clock_enable)
			r_q <= r_d;
	end

	assign rdata                   = r_q.rdata_q;
	assign cmd_list_buffer_mode    = r_q.cmd_bmod_q;
	assign result_list_buffer_mode = r_q.res_bmod_q;
	assign cmd_list_select         = r_q.cmd_sel_q;
	assign result_list_select      = r_q.res_sel_q;
	assign double_bit_ecc_fault    = r_q.ecc_fault_q;
	assign ready                   = r_q.ready_q;
	assign auto_restart_event      = r_q.wake_restart_q;
	assign current_command_write   = r_q.cmd_write_q;
	assign current_command_data    = r_q.cmd_data_q;

endmodule : adc_list_ctrl

// File: verif/adc_list_ctrl_chk.sv
`timescale 1ns/1ps
module adc_list_ctrl_chk (
	// Watched ports
	input wire logic       clock, reset, clock_enable,
	input wire logic [2:0] addr,
	input wire logic       write_strobe, read_strobe,
	input wire logic [7:0] wdata, rdata, current_command_data,
	input wire logic       converter_enable, special_mode, soft_reset,
	input wire logic       stop_in_wait, stop_exit, wait_exit,
	input wire logic       ecc_double_error, double_bit_ecc_fault, ready,
	input wire logic       cmd_list_buffer_mode, result_list_buffer_mode,
	input wire logic       cmd_list_select, result_list_select,
	input wire logic       auto_restart_event, current_command_write
);
	wire logic wake = stop_exit || (wait_exit && stop_in_wait);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// ********
	// Checks
	// ********
	property p_cs;
		!cmd_list_buffer_mode [*2] |-> !cmd_list_select;
	endproperty
	a_cs: assert property (p_cs) else $error("cmd sel");
	property p_rs;
		!result_list_buffer_mode [*2] |-> !result_list_select;
	endproperty
	a_rs: assert property (p_rs) else $error("res sel");
	// Buffer modes hold while enabled once special mode has been off for two cycles
	property p_lock;
		clock_enable && converter_enable && !special_mode
		&& $past(!special_mode) |=> $stable(cmd_list_buffer_mode)
		&& $stable(result_list_buffer_mode);
	endproperty
	a_lock: assert property (p_lock) else $error("mode lock");
	property p_eoff;
		clock_enable && !converter_enable |=> !double_bit_ecc_fault;
	endproperty
	a_eoff: assert property (p_eoff) else $error("ecc off");
	property p_eset;
		$rose(double_bit_ecc_fault) |-> $past(ecc_double_error);
	endproperty
	a_eset: assert property (p_eset) else $error("ecc set");
	property p_soft;
		clock_enable && soft_reset |=> !cmd_list_select && !result_list_select;
	endproperty
	a_soft: assert property (p_soft) else $error("soft");
	property p_sts;
		clock_enable && read_strobe && addr == 3'h2 |=> rdata[4] == 1'b0
		&& rdata[2:0] == 3'h0 && rdata[3] == $past(ready);
	endproperty
	a_sts: assert property (p_sts) else $error("status");
	property p_cmd;
		current_command_write |-> $past(write_strobe) && $past(addr) == 3'h6
		&& current_command_data == $past(wdata);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command");
	property p_auto;
		auto_restart_event |-> $past(wake) || $past(wake, 2);
	endproperty
	a_auto: assert property (p_auto) else $error("auto");
	c_tog: cover property ($rose(cmd_list_select));
	c_ecc: cover property ($rose(double_bit_ecc_fault));
	c_cmd: cover property (current_command_write);
endmodule : adc_list_ctrl_chk
bind adc_list_ctrl adc_list_ctrl_chk chk (.*);

// File: verif/adc_list_ctrl_test.sv
`timescale 1ns/1ps
module adc_list_ctrl_test;
	logic clock = 1'b0, reset = 1'b1, clock_enable = 1'b1;
	logic [2:0] addr = 3'h0;
	logic write_strobe = 1'b0, read_strobe = 1'b0;
	logic [7:0] wdata = 8'h00, rdata, current_command_data, r, v, ctl;
	logic converter_enable = 1'b0, special_mode = 1'b0, soft_reset = 1'b0;
	logic stop_in_wait = 1'b0, stop_exit = 1'b0, wait_exit = 1'b0;
	logic list_load_ok = 1'b0, restart_request = 1'b0;
	logic sequence_abort_request = 1'b0, conversion_start = 1'b0;
	logic list_end = 1'b0, result_stored = 1'b0, ecc_double_error = 1'b0;
	logic cmd_list_buffer_mode, result_list_buffer_mode, cmd_list_select;
	logic result_list_select, double_bit_ecc_fault, ready;
	logic auto_restart_event, current_command_write;
	int fail_count = 0, samples_checked = 0, test_no = 0;
	always #4 clock = ~clock;
	adc_list_ctrl dut (.*);
	// ********
	// Bus tasks
	// ********
	task check(input logic [7:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : check
	task close_out;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask : wr
	task rd(input logic [2:0] a);
		@(posedge clock);
		addr <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1 r = rdata;
	endtask : rd
	// Status poll, bounded so a stuck sequencer ends the run
	task poll(input logic [7:0] m, e);
		rd(3'h2);
		for (int i = 0; i < 16 && (r & m) !== e; i++)
			rd(3'h2);
		check(e, r & m);
		if ((r & m) !== e)
			close_out;
	endtask : poll
	task automatic watch(ref logic s);
		#1;
		for (int i = 0; i < 4 && s !== 1'b1; i++)
			@(posedge clock) #1;
		check(8'h01, {7'h0, s});
		if (s !== 1'b1)
			close_out;
	endtask : watch
	task done;
		test_no++;
		$display("test %0d finished", test_no);
	endtask : done
	initial
	begin
		void'($urandom(78));
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		rd(3'h1);
		check(8'h00, r);
		done;
		repeat (4)
		begin
			v = 8'($urandom);
			wr(3'h1, v);
			wr(3'h2, v);
			ctl = v & 8'hd0;
			rd(3'h1);
			check(ctl, r);
			check(ctl & 8'hc0, {cmd_list_buffer_mode, result_list_buffer_mode, 6'h0});
			rd(3'h2);
			check(v & ctl & 8'hc0, r);
			check(v & ctl & 8'hc0, {cmd_list_select, result_list_select, 6'h0});
		end
		done;
		wr(3'h1, 8'hc0);
		wr(3'h2, 8'h00);
		converter_enable <= 1'b1;
		poll(8'hff, 8'h08);
		wr(3'h1, 8'h10);
		rd(3'h1);
		check(8'hd0, r);
		wr(3'h2, 8'hc0);
		rd(3'h2);
		check(8'h08, r);
		done;
		list_load_ok <= 1'b1;
		restart_request <= 1'b1;
		poll(8'h88, 8'h80);
		list_load_ok <= 1'b0;
		restart_request <= 1'b0;
		ecc_double_error <= 1'b1;
		@(posedge clock);
		ecc_double_error <= 1'b0;
		poll(8'h20, 8'h20);
		check(8'h01, {7'h0, double_bit_ecc_fault});
		check(8'h00, {7'h0, ready});
		wr(3'h2, 8'h00);
		rd(3'h2);
		check(8'ha0, r);
		soft_reset <= 1'b1;
		@(posedge clock);
		soft_reset <= 1'b0;
		rd(3'h2);
		check(8'h00, r & 8'hc0);
		converter_enable <= 1'b0;
		rd(3'h2);
		check(8'h00, r & 8'h20);
		done;
		special_mode <= 1'b1;
		wr(3'h1, 8'hf0);
		converter_enable <= 1'b1;
		wr(3'h1, 8'h30);
		rd(3'h1);
		check(8'h30, r);
		wr(3'h6, 8'ha5);
		watch(current_command_write);
		check(8'ha5, current_command_data);
		stop_in_wait <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			{wait_exit, stop_exit} <= 2'h1 << k;
			@(posedge clock);
			{wait_exit, stop_exit} <= 2'h0;
			watch(auto_restart_event);
		end
		special_mode <= 1'b0;
		repeat (2) @(posedge clock);
		rd(3'h1);
		check(8'h10, r);
		done;
		// Result list double buffering: first list stored keeps list 0
		converter_enable <= 1'b0;
		wr(3'h1, 8'h40);
		converter_enable <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			poll(8'h08, 8'h08);
			restart_request <= 1'b1;
			repeat (2) @(posedge clock);
			restart_request <= 1'b0;
			conversion_start <= 1'b1;
			@(posedge clock);
			conversion_start <= 1'b0;
			result_stored <= 1'b1;
			@(posedge clock);
			result_stored <= 1'b0;
			list_end <= 1'b1;
			@(posedge clock);
			list_end <= 1'b0;
			#1 check(8'(k), {7'h0, result_list_select});
		end
		done;
		close_out;
	end
endmodule : adc_list_ctrl_test
